// >>> logic/fifo_alloc_pkg.sv
// Constants for the Ethernet packet buffer allocation block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package fifo_alloc_pkg;
	// Buffer pool and fixed partitions, in bytes or dwords
	localparam logic [15:0] POOL_BYTES = 16'h4000;
	localparam logic [15:0] TX_STATUS_BYTES = 16'h0200;
	localparam logic [7:0] TX_STATUS_DWORDS = 8'h80;
	localparam logic [15:0] RX_FULL_MARGIN = 16'h0010;
	localparam logic [11:0] TX_STAGE_BYTES = 12'h800;
	localparam logic [5:0] RX_STAGE_DWORDS = 6'h20;
	localparam logic [15:0] DWORD_BYTES = 16'h0004;
	localparam int KB_SHIFT = 10;
	localparam int RX_STS_SHIFT = 4;
	localparam int RX_STS_DW_SHIFT = 6;
	localparam int FLEN_DEPTH = 4;
	// Register byte offsets
	localparam logic [7:0] HW_CONFIG_OFS = 8'h74;
	localparam logic [7:0] RX_CONTROL_OFS = 8'h78;
	localparam logic [7:0] RX_LEVELS_OFS = 8'h7C;
	localparam logic [7:0] SIZES_OFS = 8'h90;
	localparam logic [7:0] INT_STS_OFS = 8'h94;
	localparam logic [7:0] INT_MASK_OFS = 8'h98;
	localparam logic [7:0] DROP_CNT_OFS = 8'h9C;
	localparam logic [7:0] RX_DATA_OFS = 8'hA0;
	localparam logic [7:0] RX_STATUS_OFS = 8'hA4;
	localparam logic [7:0] TX_DATA_OFS = 8'hA8;
	// Field positions
	localparam int ALLOC_LSB = 16;
	localparam int SKIP_BIT = 31;
	localparam int STS_USED_LSB = 16;
	localparam int INT_DROP = 0;
	localparam int INT_SKIP_DONE = 1;
	localparam int INT_RX_FRAME = 2;
	// Reset values and bus response codes
	localparam logic [3:0] ALLOC_RESET = 4'h5;
	localparam logic [2:0] INT_MASK_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/ethernet_fifo_allocation.sv
// Packet buffer allocation and receive/transmit FIFO level tracking.
// Assumes an AXI4-Lite master on the register side and a MAC that
// delivers padded receive dwords and drains transmit dwords.
`timescale 1ns/10ps

module ethernet_fifo_allocation import fifo_alloc_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mac_rx_valid,
	input wire logic mac_rx_last,
	output logic mac_tx_valid,
	input wire logic mac_tx_ready,
	output logic irq
);
	typedef struct packed {
		logic [3:0] alloc;
		logic skip;
		logic drop_mode;
		logic [31:0] drop_cnt;
		logic [2:0] int_sts;
		logic [2:0] int_mask;
		logic [15:0] rx_used;
		logic [7:0] rx_sts_used;
		logic [15:0] head_left;
		logic [15:0] acc;
		logic [FLEN_DEPTH-1:0][15:0] flen;
		logic [1:0] fl_wr;
		logic [1:0] fl_rd;
		logic [2:0] fl_cnt;
		logic [5:0] rxs_cnt;
		logic [31:0] rxs_last;
		logic [4:0] rxs_wr;
		logic [4:0] rxs_rd;
		logic [15:0] tx_used;
		logic [11:0] tx_stage;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_s;

	state_s cur;
	state_s next_cur;
	logic [15:0] tx_total;
	logic [15:0] tx_data_cap;
	logic [15:0] rx_total;
	logic [15:0] rx_sts_bytes;
	logic [15:0] rx_data_cap;
	logic [15:0] rx_sts_dw_wide;
	logic [7:0] rx_sts_cap;
	logic rx_full;
	logic wr_go;
	logic rd_go;

	// Partition of the pool; reserved settings give no sensible split
	assign tx_total = {2'h0, cur.alloc, 10'h000};
	assign tx_data_cap = tx_total - TX_STATUS_BYTES;
	assign rx_total = POOL_BYTES - tx_total;
	assign rx_sts_bytes = rx_total >> RX_STS_SHIFT;
	assign rx_data_cap = rx_total - rx_sts_bytes;
	assign rx_sts_dw_wide = rx_total >> RX_STS_DW_SHIFT;
	assign rx_sts_cap = rx_sts_dw_wide[7:0];
	assign rx_full = (cur.rx_used + RX_FULL_MARGIN) > rx_data_cap;

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !cur.bvalid;
	assign rd_go = s_axi_arvalid && !cur.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rresp = cur.rresp;
	assign s_axi_rdata = cur.rdata;
	assign mac_tx_valid = cur.tx_stage != 12'h000;
	assign irq = |(cur.int_sts & cur.int_mask);

	always_comb begin
		logic [31:0] wmask;
		logic [2:0] ev;
		logic mv_in;
		logic mv_last;
		logic fl_pop;
		logic [15:0] eff_head;
		logic consume;
		logic data_rd;
		logic sts_rd;
		logic tx_wr;
		logic tx_mv;
		logic tx_out;
		logic st_push;
		logic st_pop;
		logic overrun;
		next_cur = cur;
		wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
			{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		ev = 3'h0;
		mv_in = 1'b0;
		mv_last = 1'b0;
		fl_pop = 1'b0;
		eff_head = cur.head_left;
		consume = 1'b0;
		data_rd = rd_go && s_axi_araddr == RX_DATA_OFS;
		sts_rd = rd_go && s_axi_araddr == RX_STATUS_OFS;
		tx_wr = wr_go && s_axi_awaddr == TX_DATA_OFS;
		tx_mv = 1'b0;
		tx_out = 1'b0;
		st_push = 1'b0;
		st_pop = 1'b0;
		overrun = 1'b0;

		// Bus responses
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
		end
		if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
		end
		if (wr_go) begin
			next_cur.bvalid = 1'b1;
			next_cur.bresp = RESP_OKAY;
			case (s_axi_awaddr)
				HW_CONFIG_OFS: begin
					if (s_axi_wstrb[2]) begin
						next_cur.alloc = s_axi_wdata[ALLOC_LSB +: 4];
					end
				end
				RX_CONTROL_OFS: begin
					if ((s_axi_wdata[SKIP_BIT] & wmask[SKIP_BIT]) == 1'b1) begin
						next_cur.skip = 1'b1;
					end
				end
				INT_MASK_OFS: begin
					next_cur.int_mask = (s_axi_wdata[2:0] & wmask[2:0]) |
						(cur.int_mask & ~wmask[2:0]);
				end
				INT_STS_OFS, TX_DATA_OFS: begin
				end
				default: begin
					next_cur.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (rd_go) begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = RESP_OKAY;
			next_cur.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				HW_CONFIG_OFS: next_cur.rdata[ALLOC_LSB +: 4] = cur.alloc;
				RX_CONTROL_OFS: next_cur.rdata[SKIP_BIT] = cur.skip;
				RX_LEVELS_OFS: begin
					next_cur.rdata[STS_USED_LSB +: 8] = cur.rx_sts_used;
					next_cur.rdata[15:0] = cur.rx_used;
				end
				SIZES_OFS: next_cur.rdata = {rx_data_cap, tx_data_cap};
				INT_STS_OFS: next_cur.rdata[2:0] = cur.int_sts;
				INT_MASK_OFS: next_cur.rdata[2:0] = cur.int_mask;
				DROP_CNT_OFS: next_cur.rdata = cur.drop_cnt;
				RX_DATA_OFS: next_cur.rdata[15:0] = cur.rx_used;
				RX_STATUS_OFS: next_cur.rdata[7:0] = cur.rx_sts_used;
				default: next_cur.rresp = RESP_SLVERR;
			endcase
		end

		// Receive: MAC into staging, overrun drops the rest of the frame
		if (mac_rx_valid) begin
			if (cur.drop_mode || cur.rxs_cnt == RX_STAGE_DWORDS) begin
				overrun = 1'b1;
				next_cur.drop_mode = 1'b1;
				if (mac_rx_last) begin
					next_cur.drop_cnt = cur.drop_cnt + 32'h0000_0001;
					ev[INT_DROP] = 1'b1;
					next_cur.drop_mode = rx_full;
				end
			end else begin
				st_push = 1'b1;
				next_cur.rxs_last[cur.rxs_wr] = mac_rx_last;
				next_cur.rxs_wr = cur.rxs_wr + 5'h01;
			end
		end

		// Staging into data FIFO only while the data, status and frame-length FIFOs have room
		if (cur.rxs_cnt != 6'h00 && !rx_full && cur.rx_sts_used < rx_sts_cap &&
			cur.fl_cnt != 3'(FLEN_DEPTH)) begin
			st_pop = 1'b1;
			mv_in = 1'b1;
			mv_last = cur.rxs_last[cur.rxs_rd];
			next_cur.rxs_rd = cur.rxs_rd + 5'h01;
		end
		next_cur.rxs_cnt = cur.rxs_cnt + {5'h00, st_push} - {5'h00, st_pop};
		if (mv_in) begin
			next_cur.acc = cur.acc + DWORD_BYTES;
			if (mv_last) begin
				next_cur.flen[cur.fl_wr] = cur.acc + DWORD_BYTES;
				next_cur.fl_wr = cur.fl_wr + 2'h1;
				next_cur.acc = 16'h0000;
				ev[INT_RX_FRAME] = 1'b1;
			end
		end

		// Host reads and fast-forward consume from the head frame
		if (cur.head_left == 16'h0000 && cur.fl_cnt != 3'h0 &&
			(data_rd || cur.skip)) begin
			fl_pop = 1'b1;
			eff_head = cur.flen[cur.fl_rd];
			next_cur.fl_rd = cur.fl_rd + 2'h1;
		end
		if (cur.skip) begin
			if (eff_head == 16'h0000) begin
				next_cur.skip = 1'b0;
				ev[INT_SKIP_DONE] = 1'b1;
			end else if (cur.rx_used >= DWORD_BYTES) begin
				consume = 1'b1;
				if (eff_head == DWORD_BYTES) begin
					next_cur.skip = 1'b0;
					ev[INT_SKIP_DONE] = 1'b1;
				end
			end
		end else if (data_rd && cur.rx_used >= DWORD_BYTES) begin
			consume = 1'b1;
		end
		// A new skip request beats the completion of the previous one
		if (wr_go && s_axi_awaddr == RX_CONTROL_OFS && s_axi_wdata[SKIP_BIT] &&
			s_axi_wstrb[3]) begin
			next_cur.skip = 1'b1;
		end
		next_cur.head_left = (consume && eff_head != 16'h0000) ?
			eff_head - DWORD_BYTES : eff_head;
		next_cur.fl_cnt = cur.fl_cnt + {2'h0, mv_in && mv_last} - {2'h0, fl_pop};
		next_cur.rx_used = cur.rx_used + (mv_in ? DWORD_BYTES : 16'h0000) -
			(consume ? DWORD_BYTES : 16'h0000);
		next_cur.rx_sts_used = cur.rx_sts_used + {7'h00, mv_in && mv_last} -
			{7'h00, sts_rd && cur.rx_sts_used != 8'h00};

		// Transmit: host fills data FIFO, staging refills, MAC drains
		if (tx_wr && cur.tx_used + DWORD_BYTES <= tx_data_cap) begin
			tx_wr = 1'b1;
		end else begin
			tx_wr = 1'b0;
		end
		if (cur.tx_used >= DWORD_BYTES &&
			cur.tx_stage + 12'h004 <= TX_STAGE_BYTES) begin
			tx_mv = 1'b1;
		end
		tx_out = mac_tx_valid && mac_tx_ready;
		next_cur.tx_used = cur.tx_used + (tx_wr ? DWORD_BYTES : 16'h0000) -
			(tx_mv ? DWORD_BYTES : 16'h0000);
		next_cur.tx_stage = cur.tx_stage + (tx_mv ? 12'h004 : 12'h000) -
			(tx_out ? 12'h004 : 12'h000);

		// Sticky events; a new event beats a simultaneous clear
		if (wr_go && s_axi_awaddr == INT_STS_OFS) begin
			next_cur.int_sts = cur.int_sts & ~(s_axi_wdata[2:0] & wmask[2:0]);
		end
		next_cur.int_sts = next_cur.int_sts | ev;
		if (overrun && !mac_rx_last) begin
			next_cur.drop_mode = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
			cur.alloc <= ALLOC_RESET;
			cur.int_mask <= INT_MASK_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_rx_split_sum: assert property (
		rx_data_cap + rx_sts_bytes + tx_total == POOL_BYTES &&
		{rx_sts_cap, 6'h00} == rx_total)
		else $error("receive split does not add up");
	a_tx_split: assert property (
		tx_data_cap + TX_STATUS_BYTES == {2'h0, cur.alloc, 10'h000})
		else $error("transmit split wrong");
	a_full_holds: assert property (
		rx_full && !cur.skip && !(s_axi_arvalid && s_axi_araddr == RX_DATA_OFS)
		|=> cur.rx_used == $past(cur.rx_used))
		else $error("data FIFO grew while full");
	a_stage_bounds: assert property (
		cur.tx_stage <= TX_STAGE_BYTES && cur.rxs_cnt <= RX_STAGE_DWORDS)
		else $error("staging buffer beyond its size");
	a_tx_refill: assert property (
		cur.tx_used >= DWORD_BYTES && cur.tx_stage == 12'h000
		|=> cur.tx_stage == 12'h004)
		else $error("staging not refilled");
	a_drop_count: assert property (
		mac_rx_valid && mac_rx_last && cur.drop_mode
		|=> cur.drop_cnt == $past(cur.drop_cnt) + 32'h0000_0001 && cur.int_sts[INT_DROP])
		else $error("lost frame not counted");
	a_skip_visible: assert property (
		wr_go && s_axi_awaddr == RX_CONTROL_OFS && s_axi_wdata[SKIP_BIT] && s_axi_wstrb[3]
		##2 (s_axi_arvalid && s_axi_araddr == RX_CONTROL_OFS && !s_axi_rvalid && cur.skip)
		|=> s_axi_rdata[SKIP_BIT])
		else $error("skip bit not read high");
	a_levels_reset: assert property (
		$rose(aresetn) |-> cur.rx_used == 16'h0000 && cur.rx_sts_used == 8'h00)
		else $error("levels not zero after reset");
	a_frame_adds: assert property (
		cur.rxs_cnt != 6'h00 && !rx_full && cur.rx_sts_used < rx_sts_cap &&
		cur.fl_cnt != 3'h4 && !cur.skip && !s_axi_arvalid
		|=> cur.rx_used == $past(cur.rx_used) + DWORD_BYTES)
		else $error("data level did not grow");
	a_status_read: assert property (
		s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == RX_STATUS_OFS &&
		cur.rx_sts_used != 8'h00 && !(cur.rxs_cnt != 6'h00 && cur.rxs_last[cur.rxs_rd])
		|=> cur.rx_sts_used == $past(cur.rx_sts_used) - 8'h01)
		else $error("status level not reduced");

	c_skip_done: cover property (cur.skip ##1 !cur.skip);
	c_frame_drop: cover property (mac_rx_valid && mac_rx_last && cur.drop_mode);
	c_irq: cover property ($rose(irq));
	c_rx_full: cover property (rx_full && cur.rxs_cnt == RX_STAGE_DWORDS);
endmodule

// >>> tb/mac_model.sv
// MAC-side model: sends padded receive frames and drains transmit dwords.
// Assumes one clock shared with the buffer block.
`timescale 1ns/10ps
module mac_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic [9:0] len,
	input wire logic tx_stall,
	input wire logic mac_tx_valid,
	output logic mac_rx_valid,
	output logic mac_rx_last,
	output logic mac_tx_ready,
	output logic [9:0] tx_count,
	output logic busy
);
	logic [9:0] left;
	// One padded dword a cycle, never stalled
	assign mac_rx_valid = (left != 10'h000);
	assign mac_rx_last = (left == 10'h001);
	assign busy = mac_rx_valid;
	assign mac_tx_ready = !tx_stall;
	always @(posedge aclk) begin
		if (!aresetn) begin
			left <= 10'h000;
			tx_count <= 10'h000;
		end else begin
			if (go)
				left <= len;
			else if (left != 10'h000)
				left <= left - 10'h001;
			if (mac_tx_valid && mac_tx_ready)
				tx_count <= tx_count + 10'h001;
		end
	end
endmodule

// >>> tb/ethernet_fifo_allocation_tb_top.sv
// Bench for the packet buffer allocation block over AXI4-Lite.
// Assumes the MAC model drives the network side.
`timescale 1ns/10ps
module ethernet_fifo_allocation_tb_top;
	import fifo_alloc_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic mac_rx_valid, mac_rx_last, mac_tx_valid, mac_tx_ready, irq, busy;
	logic go = 0, tx_stall = 0;
	logic [9:0] len = 10'h000, tx_count;
	int error_cnt = 0, samples_checked = 0, v, rx_alloc;
	always #12.5 aclk = ~aclk;
	ethernet_fifo_allocation DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .mac_rx_valid, .mac_rx_last, .mac_tx_valid, .mac_tx_ready,
		.irq);
	mac_model mac (.aclk, .aresetn, .go, .len, .tx_stall, .mac_tx_valid, .mac_rx_valid,
		.mac_rx_last, .mac_tx_ready, .tx_count, .busy);
	task automatic complete_run();
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bound(input int n);
		if (n >= 3000) begin
			error_cnt++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (s_axi_awready !== 1'b1 && n < 3000);
		bound(n);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		n = 0;
		do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 3000);
		bound(n);
		rs = s_axi_bresp;
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		n = 0;
		do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 3000);
		bound(n);
		s_axi_arvalid <= 0;
		n = 0;
		do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 3000);
		bound(n);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(rd, e);
	endtask
	// Reads until the expected value shows, then compares
	task automatic poll(input logic [7:0] a, input logic [31:0] e);
		int n;
		n = 0;
		do begin rdr(a); n++; end while (rd !== e && n < 3000);
		chk(rd, e);
		bound(n);
	endtask
	task automatic frame(input logic [9:0] l);
		int n;
		len <= l;
		go <= 1;
		@(posedge aclk);
		go <= 0;
		n = 0;
		do begin @(posedge aclk); n++; end while (busy !== 1'b0 && n < 3000);
		bound(n);
	endtask
	task automatic do_reset();
		aresetn <= 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
	endtask
	initial begin
		do_reset();
		rc(HW_CONFIG_OFS, 32'h00050000);
		rc(SIZES_OFS, 32'h29401200);
		rc(RX_LEVELS_OFS, 32'h00000000);
		rc(8'h00, 32'h00000000);
		chk(rs, RESP_SLVERR);
		wr(8'h00, 32'hFFFFFFFF);
		chk(rs, RESP_SLVERR);
		// Only legal allocation values are programmed
		for (v = 2; v <= 14; v++) begin
			wr(HW_CONFIG_OFS, v << 16);
			rx_alloc = 16384 - v * 1024;
			rc(SIZES_OFS, {16'(rx_alloc - rx_alloc / 16), 16'(v * 1024 - 512)});
		end
		wr(HW_CONFIG_OFS, 32'h00060000);
		chk(rs, RESP_OKAY);
		frame(10'd3);
		poll(RX_LEVELS_OFS, 32'h0001000C);
		rc(INT_STS_OFS, 32'h00000004);
		chk(irq, 1'b0);
		wr(INT_MASK_OFS, 32'h00000004);
		chk(irq, 1'b1);
		wr(INT_STS_OFS, 32'h00000004);
		chk(irq, 1'b0);
		rc(RX_DATA_OFS, 32'h0000000C);
		rc(RX_STATUS_OFS, 32'h00000001);
		rc(RX_LEVELS_OFS, 32'h00000008);
		// Only the control register is read while skipping
		wr(RX_CONTROL_OFS, 32'h80000000);
		poll(RX_CONTROL_OFS, 32'h00000000);
		rc(RX_LEVELS_OFS, 32'h00000000);
		rc(INT_STS_OFS, 32'h00000002);
		// Overrun at the smallest receive allocation
		wr(HW_CONFIG_OFS, 32'h000E0000);
		frame(10'd540);
		frame(10'd2);
		poll(DROP_CNT_OFS, 32'h00000002);
		rc(RX_LEVELS_OFS, 32'h00000774);
		rc(INT_STS_OFS, 32'h00000003);
		do_reset();
		rc(DROP_CNT_OFS, 32'h00000000);
		tx_stall <= 1;
		repeat (3) wr(TX_DATA_OFS, 32'h0000A5A5);
		repeat (4) @(posedge aclk);
		chk(mac_tx_valid, 1'b1);
		chk(tx_count, 10'h000);
		tx_stall <= 0;
		v = 0;
		do begin @(posedge aclk); v++; end while (tx_count !== 10'h003 && v < 3000);
		chk(tx_count, 10'h003);
		bound(v);
		complete_run();
	end
endmodule
